// >>> core/bfd_pkg.sv
// Package for the bridge fault and diagnostic block: register map, field layout and timing constants.
// Assumes a 40 MHz core clock and an APB master that reaches the control and status words.
package bfd_pkg;

	localparam int CLK_MHZ = 40;
	localparam int CLK_KHZ = 40000;

	// Blanking delay is one to four microseconds, selected by a two-bit code.
	localparam int BLANK_BASE_US = 1;
	localparam int BLANK_BASE_CYC = BLANK_BASE_US * CLK_MHZ;
	// Open-load lockout is ten to forty milliseconds.
	localparam int OL_BASE_MS = 10;
	localparam int OL_BASE_CYC_DEF = OL_BASE_MS * CLK_KHZ;

	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STEP_ANGLE = 8'h08;
	localparam logic [7:0] ADDR_BRIDGE_FAULT = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_STATUS_CLR = 8'h14;

	// Config word fields.
	localparam int CFG_MXI_LSB = 0;
	localparam int CFG_TOC_LSB = 4;
	localparam int CFG_TOL_LSB = 6;
	localparam int CFG_OFA_BIT = 8;
	localparam int CFG_OLT_BIT = 9;
	localparam int CFG_SPF_BIT = 10;
	localparam int CFG_GEN_BIT = 11;
	localparam logic [11:0] CFG_RESET = 12'h800;

	// Control word fields.
	localparam int CTRL_SLP_BIT = 0;

	// Status word fields.
	localparam int ST_OCA = 0;
	localparam int ST_OCB = 1;
	localparam int ST_OLA = 2;
	localparam int ST_OLB = 3;
	localparam int ST_POR = 14;
	localparam int ST_FF = 15;
	localparam logic [15:0] ST_RESET = 16'hc000;

	localparam logic [5:0] HOME_SINGLE = 6'h00;
	localparam logic [5:0] HOME_OTHER = 6'h08;
	localparam logic [3:0] MXI_LOW_MAX = 4'h1;

	typedef struct packed {
		logic [7:0] oc_raw;
		logic [1:0] ol_below;
		logic [1:0] ol_target_ok;
		logic [1:0] trip_reached;
	} bfd_analog_t;

	typedef struct packed {
		logic gen_flag_sel;
		logic single_phase;
		logic level_sel;
		logic retry_disable;
		logic [1:0] ol_delay;
		logic [1:0] blank_sel;
		logic [3:0] max_code;
	} bfd_cfg_t;

endpackage

// >>> core/bfd_top.sv
// Bridge fault detection and clearing logic: blanking, latching, open-load lockout and clear sources.
// Assumes the analog comparator outputs, the step and reset_sleep pins are asynchronous to core_clk.
`timescale 1ns/1ps

module bfd_top #(
	parameter int OL_BASE_CYC = bfd_pkg::OL_BASE_CYC_DEF
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins and analog monitors
	input wire logic step_pin,
	input wire logic reset_sleep_pin,
	input wire bfd_pkg::bfd_analog_t analog_in,
	input wire logic [5:0] step_angle_in,
	input wire logic step_angle_load,
	// Outputs
	output logic fault_out_pin,
	output logic [1:0] bridge_enable,
	output logic low_thresh_reduced,
	output logic ol_level_high,
	output logic [5:0] step_angle
);

	localparam int OL_W = 23;

	bfd_pkg::bfd_analog_t an_s1_q, an_s2_q;
	logic [2:0] step_s_q, rst_s_q;
	logic [11:0] cfg_q, cfg_d;
	logic sleep_bit_q, sleep_bit_d;
	logic slept_q, slept_d;
	logic [7:0] bridge_fault_q, bridge_fault_d;
	logic [15:0] status_q, status_d;
	logic [5:0] angle_q, angle_d;
	logic [7:0] oc_fault_q, oc_fault_d;
	logic [1:0] ol_state_q, ol_state_d;
	logic [7:0] blank_cnt_q [8];
	logic [7:0] blank_cnt_d [8];
	logic [OL_W-1:0] ol_cnt_q, ol_cnt_d;
	logic ol_armed_q, ol_armed_d;
	logic [31:0] prdata_q, prdata_d;
	logic step_rise, rst_rise, in_sleep, wake_clear, pulse_clear;
	logic apb_acc, apb_wr, apb_rd, apb_setup_rd;
	logic rd_bridge, wr_status, oc_clear, ol_sample;
	logic [7:0] blank_term;
	logic [OL_W-1:0] ol_term;
	bfd_pkg::bfd_cfg_t cfg;

	assign cfg = bfd_pkg::bfd_cfg_t'(cfg_q);
	assign apb_acc = psel && penable;
	assign apb_wr = apb_acc && pwrite;
	assign apb_rd = apb_acc && !pwrite;
	assign apb_setup_rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = prdata_q;

	// Both pins and comparator outputs pass two flops before any use.
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			an_s1_q <= '0;
			an_s2_q <= '0;
			step_s_q <= 3'h0;
			rst_s_q <= 3'h7;
		end
		else
		begin
			an_s1_q <= analog_in;
			an_s2_q <= an_s1_q;
			step_s_q <= {step_s_q[1:0], step_pin};
			rst_s_q <= {rst_s_q[1:0], reset_sleep_pin};
		end
	end

	assign step_rise = step_s_q[1] && !step_s_q[2];
	assign rst_rise = rst_s_q[1] && !rst_s_q[2];
	assign in_sleep = !rst_s_q[2] || sleep_bit_q;
	// Any low on the pin counts as sleep; the pulse and the wake clear the same fault state, and only the wake homes the step angle.
	assign pulse_clear = rst_rise;
	assign wake_clear = slept_q && !in_sleep;
	assign rd_bridge = apb_rd && (paddr == bfd_pkg::ADDR_BRIDGE_FAULT);
	assign wr_status = apb_wr;
	assign oc_clear = rd_bridge || pulse_clear || wake_clear || (step_rise && !cfg.retry_disable);
	assign low_thresh_reduced = cfg.max_code <= bfd_pkg::MXI_LOW_MAX;
	assign ol_level_high = cfg.level_sel;
	assign blank_term = 8'((32'(cfg.blank_sel) + 32'd1) * bfd_pkg::BLANK_BASE_CYC);
	assign ol_term = OL_W'((32'(cfg.ol_delay) + 32'd1) * OL_BASE_CYC);
	assign ol_sample = ol_armed_q && (ol_cnt_q == ol_term);

	// Register writes land at the access edge of a write transfer.
	always_comb
	begin
		cfg_d = cfg_q;
		if (apb_wr && paddr == bfd_pkg::ADDR_CFG)
		begin
			cfg_d = pwdata[11:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			cfg_q <= bfd_pkg::CFG_RESET;
		else
			cfg_q <= cfg_d;
	end

	always_comb
	begin
		sleep_bit_d = sleep_bit_q;
		if (apb_wr && paddr == bfd_pkg::ADDR_CTRL)
		begin
			sleep_bit_d = pwdata[bfd_pkg::CTRL_SLP_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			sleep_bit_q <= 1'b0;
		else
			sleep_bit_q <= sleep_bit_d;
	end

	// Read data is captured in the setup cycle so that it already stands at the access edge.
	// A clear-on-read then acts at that same edge without hiding the word being returned.
	always_comb
	begin
		prdata_d = prdata_q;
		if (apb_setup_rd)
		begin
			case (paddr)
				bfd_pkg::ADDR_CFG: prdata_d = {20'h0, cfg_q};
				bfd_pkg::ADDR_CTRL: prdata_d = {31'h0, sleep_bit_q};
				bfd_pkg::ADDR_STEP_ANGLE: prdata_d = {26'h0, angle_q};
				bfd_pkg::ADDR_BRIDGE_FAULT: prdata_d = {24'h0, bridge_fault_q};
				bfd_pkg::ADDR_STATUS: prdata_d = {16'h0, status_q};
				default: prdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			prdata_q <= 32'h0;
		else
			prdata_q <= prdata_d;
	end

	// The sleep memory is set while asleep and dropped by the wake clear it causes.
	always_comb
	begin
		slept_d = slept_q;
		if (in_sleep)
			slept_d = 1'b1;
		else if (wake_clear)
			slept_d = 1'b0;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			slept_q <= 1'b0;
		else
			slept_q <= slept_d;
	end

	// Homing on wake takes priority over a translator load in the same cycle.
	always_comb
	begin
		angle_d = angle_q;
		if (wake_clear)
		begin
			angle_d = cfg.single_phase ? bfd_pkg::HOME_SINGLE : bfd_pkg::HOME_OTHER;
		end
		else if (step_angle_load)
		begin
			angle_d = step_angle_in;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			angle_q <= bfd_pkg::HOME_OTHER;
		else
			angle_q <= angle_d;
	end

	// Blanking counter per transistor; a gap in the condition restarts it.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_blank
			always_comb
			begin
				blank_cnt_d[gi] = 8'h0;
				if (an_s2_q.oc_raw[gi] && !oc_fault_q[gi])
				begin
					blank_cnt_d[gi] = (blank_cnt_q[gi] == blank_term) ? blank_cnt_q[gi] : blank_cnt_q[gi] + 8'h1;
				end
			end
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					blank_cnt_q[gi] <= 8'h0;
				else
					blank_cnt_q[gi] <= blank_cnt_d[gi];
			end
		end
	endgenerate

	always_comb
	begin
		oc_fault_d = oc_fault_q;
		bridge_fault_d = bridge_fault_q;
		status_d = status_q;
		ol_state_d = ol_state_q;
		ol_cnt_d = ol_cnt_q;
		ol_armed_d = ol_armed_q;
		// Clears first so that a detection in the same cycle wins.
		if (oc_clear)
		begin
			oc_fault_d = 8'h0;
		end
		if (rd_bridge || pulse_clear || wake_clear)
		begin
			bridge_fault_d = 8'h0;
			status_d[bfd_pkg::ST_OCA] = 1'b0;
			status_d[bfd_pkg::ST_OCB] = 1'b0;
		end
		if (wr_status || pulse_clear || wake_clear)
		begin
			ol_state_d = 2'h0;
			status_d[bfd_pkg::ST_OLA] = 1'b0;
			status_d[bfd_pkg::ST_OLB] = 1'b0;
		end
		if (wr_status)
		begin
			status_d[bfd_pkg::ST_POR] = 1'b0;
			status_d[bfd_pkg::ST_FF] = 1'b0;
		end
		for (int i = 0; i < 8; i++)
		begin
			if (blank_cnt_q[i] == blank_term && an_s2_q.oc_raw[i])
			begin
				oc_fault_d[i] = 1'b1;
				bridge_fault_d[i] = 1'b1;
			end
		end
		if (|bridge_fault_d[3:0])
			status_d[bfd_pkg::ST_OCA] = 1'b1;
		if (|bridge_fault_d[7:4])
			status_d[bfd_pkg::ST_OCB] = 1'b1;
		// Lockout restarts on every step command.
		if (step_rise)
		begin
			ol_cnt_d = '0;
			ol_armed_d = 1'b1;
			ol_state_d = 2'h0;
		end
		else if (ol_sample)
		begin
			ol_armed_d = 1'b0;
			for (int p = 0; p < 2; p++)
			begin
				if (an_s2_q.ol_target_ok[p])
				begin
					ol_state_d[p] = an_s2_q.ol_below[p];
				end
			end
		end
		else if (ol_armed_q)
		begin
			ol_cnt_d = ol_cnt_q + 1'b1;
		end
		for (int p = 0; p < 2; p++)
		begin
			if (an_s2_q.trip_reached[p])
				ol_state_d[p] = 1'b0;
			if (ol_state_d[p])
				status_d[bfd_pkg::ST_OLA + p] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			oc_fault_q <= 8'h0;
			bridge_fault_q <= 8'h0;
			status_q <= bfd_pkg::ST_RESET;
		end
		else
		begin
			oc_fault_q <= oc_fault_d;
			bridge_fault_q <= bridge_fault_d;
			status_q <= status_d;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ol_state_q <= 2'h0;
			ol_cnt_q <= '0;
			ol_armed_q <= 1'b0;
		end
		else
		begin
			ol_state_q <= ol_state_d;
			ol_cnt_q <= ol_cnt_d;
			ol_armed_q <= ol_armed_d;
		end
	end

	// Open-load never stops the bridge; only latched shorts and sleep do.
	assign bridge_enable[0] = !(|oc_fault_q[3:0]) && !in_sleep;
	assign bridge_enable[1] = !(|oc_fault_q[7:4]) && !in_sleep;
	// Step edges clear only the live fault, never the registers, so the pin follows live state.
	assign fault_out_pin = !(cfg.gen_flag_sel && ((|oc_fault_q) || (|ol_state_q)));
	assign step_angle = angle_q;

endmodule

// >>> tb/bfd_chk.sv
// Port-level assertions for the bridge fault block.
// Assumes the general fault flag stays selected and sleep is entered only through the pin.
`timescale 1ns/1ps
module bfd_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic step_pin,
	input wire logic reset_sleep_pin,
	input wire bfd_pkg::bfd_analog_t analog_in,
	input wire logic step_angle_load,
	input wire logic fault_out_pin,
	input wire logic [1:0] bridge_enable,
	input wire logic low_thresh_reduced,
	input wire logic ol_level_high,
	input wire logic [5:0] step_angle
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic acc = psel && penable;
	wire logic cfg_wr = acc && pwrite && paddr == bfd_pkg::ADDR_CFG;
	thresh_sel_a: assert property (cfg_wr |=> low_thresh_reduced == ($past(pwdata[3:0]) <= 4'h1))
		else $error("threshold select wrong");
	level_sel_a: assert property (cfg_wr |=> ol_level_high == $past(pwdata[9]))
		else $error("level select wrong");
	blank_hold_a: assert property ($fell(fault_out_pin) && !(|analog_in.ol_below) |->
		$past(|analog_in.oc_raw, 40)) else $error("fault before blanking");
	bridge_off_a: assert property ($fell(bridge_enable[0]) && reset_sleep_pin |->
		$past(|analog_in.oc_raw[3:0], 40)) else $error("bridge off without fault");
	fault_low_a: assert property (!bridge_enable[0] && reset_sleep_pin && $past(reset_sleep_pin, 3)
		&& $past(nrst, 2) |-> !fault_out_pin) else $error("fault pin high");
	ready_a: assert property (acc |-> pready && !pslverr) else $error("bus not ready");
	angle_keep_a: assert property (!$past(step_angle_load) && !$past(psel) && reset_sleep_pin
		&& $past(reset_sleep_pin, 6) |-> $stable(step_angle)) else $error("angle changed");
	read_clear_a: assert property (acc && !pwrite && paddr == bfd_pkg::ADDR_BRIDGE_FAULT
		&& !(|analog_in.oc_raw) && reset_sleep_pin && $past(reset_sleep_pin, 3) |-> ##[1:3] &bridge_enable)
		else $error("read did not re-enable");
	rd_cov: cover property (acc && !pwrite && paddr == bfd_pkg::ADDR_BRIDGE_FAULT);
	flt_cov: cover property ($fell(fault_out_pin));
	stp_cov: cover property ($rose(step_pin) && !bridge_enable[1]);
endmodule

bind bfd_top bfd_chk u_chk (.*);

// >>> tb/bfd_host.sv
// Host model driving the step and reset or sleep pins.
// Assumes its tasks are called from one bench process.
`timescale 1ns/1ps
module bfd_host (
	// Clock
	input wire logic core_clk,
	// Pins
	output logic step_pin,
	output logic reset_sleep_pin
);
	initial
	begin
		step_pin = 1'b0;
		reset_sleep_pin = 1'b1;
	end
	// Pins are held for several cycles so the block's synchronisers always see them.
	task automatic step();
		@(posedge core_clk);
		step_pin <= 1'b1;
		repeat (3) @(posedge core_clk);
		step_pin <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic pulse(input int n);
		@(posedge core_clk);
		reset_sleep_pin <= 1'b0;
		repeat (n) @(posedge core_clk);
		reset_sleep_pin <= 1'b1;
		repeat (8) @(posedge core_clk);
	endtask
endmodule

// >>> tb/bfd_top_bench.sv
// Self-checking bench for the bridge fault block.
// Assumes the bus map and latencies of the design, with a short open-load base count.
`timescale 1ns/1ps
module bfd_top_bench;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic [1:0] en;
	logic fp;
	logic lthr;
	logic lvl;
	logic stp;
	logic rsp;
	logic [5:0] ang;
	logic [5:0] ang_in = 6'h00;
	logic ang_ld = 1'b0;
	bfd_pkg::bfd_analog_t an = '0;
	int n_mismatch = 0;
	int checks = 0;
	always #12.5 core_clk = ~core_clk;
	bfd_top #(.OL_BASE_CYC(50)) u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
		.step_pin(stp), .reset_sleep_pin(rsp), .analog_in(an), .step_angle_in(ang_in),
		.step_angle_load(ang_ld), .fault_out_pin(fp), .bridge_enable(en), .low_thresh_reduced(lthr),
		.ol_level_high(lvl), .step_angle(ang));
	bfd_host u_host (.core_clk(core_clk), .step_pin(stp), .reset_sleep_pin(rsp));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Read data is taken at the edge that completes the access; one idle edge lets outputs settle.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdr(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic cfg(input logic [11:0] v);
		apb(1'b1, bfd_pkg::ADDR_CFG, 32'(v));
	endtask
	task automatic oc(input logic [7:0] v, input int n);
		an.oc_raw <= v;
		repeat (n) @(posedge core_clk);
	endtask
	task automatic t_por();
		rdr(bfd_pkg::ADDR_STATUS);
		chk("status", 32'(bfd_pkg::ST_RESET), rd);
		rdr(bfd_pkg::ADDR_CFG);
		chk("cfg", 32'(bfd_pkg::CFG_RESET), rd);
		chk("enable", 32'h3, 32'(en));
	endtask
	task automatic t_cfg();
		for (int c = 0; c < 16; c++)
		begin
			cfg({2'h2, c[0], 5'h00, c[3:0]});
			chk("reduced", 32'(c < 2), 32'(lthr));
			chk("level", 32'(c[0]), 32'(lvl));
		end
	endtask
	task automatic t_blank();
		cfg(12'h810);
		oc(8'h02, 70);
		oc(8'h00, 10);
		chk("short pulse", 32'h3, 32'(en));
		oc(8'h02, 90);
		chk("latched", 32'h2, 32'(en));
		chk("pin low", 32'h0, 32'(fp));
		oc(8'h00, 4);
		rdr(bfd_pkg::ADDR_STATUS);
		chk("status", 32'h1, rd & 32'hc001);
		rdr(bfd_pkg::ADDR_BRIDGE_FAULT);
		chk("fault bits", 32'h2, rd);
		rdr(bfd_pkg::ADDR_STATUS);
		chk("flags read", 32'h0, rd & 32'h3);
		chk("reenabled", 32'h3, 32'(en));
		chk("pin high", 32'h1, 32'(fp));
	endtask
	task automatic t_retry();
		cfg(12'h800);
		oc(8'h10, 50);
		oc(8'h00, 4);
		u_host.step();
		chk("step retry", 32'h3, 32'(en));
		chk("pin retry", 32'h1, 32'(fp));
		rdr(bfd_pkg::ADDR_STATUS);
		chk("flag kept", 32'h2, rd & 32'h3);
		cfg(12'h900);
		oc(8'h10, 50);
		oc(8'h00, 4);
		u_host.step();
		chk("no retry", 32'h1, 32'(en));
		u_host.pulse(8);
		chk("pulse clr", 32'h3, 32'(en));
		rdr(bfd_pkg::ADDR_STATUS);
		chk("flags pulse", 32'h0, rd & 32'h3);
	endtask
	task automatic t_ol();
		cfg(12'h800);
		an.ol_below <= 2'b11;
		an.ol_target_ok <= 2'b01;
		u_host.step();
		chk("lockout", 32'h1, 32'(fp));
		repeat (60) @(posedge core_clk);
		chk("open load", 32'h0, 32'(fp));
		chk("drive kept", 32'h3, 32'(en));
		rdr(bfd_pkg::ADDR_STATUS);
		chk("load flags", 32'h4, rd & 32'hc);
		an.trip_reached <= 2'b01;
		repeat (4) @(posedge core_clk);
		chk("trip clr", 32'h1, 32'(fp));
		an.trip_reached <= 2'b00;
		u_host.step();
		chk("step clr", 32'h1, 32'(fp));
		an.ol_below <= 2'b00;
		repeat (60) @(posedge core_clk);
		apb(1'b1, bfd_pkg::ADDR_STATUS_CLR, 32'h0);
		rdr(bfd_pkg::ADDR_STATUS);
		chk("flags clr", 32'h0, rd & 32'hc);
		chk("pin clr", 32'h1, 32'(fp));
	endtask
	task automatic t_angle(input logic [11:0] v, input logic [5:0] home);
		cfg(v);
		ang_in <= 6'h05;
		ang_ld <= 1'b1;
		@(posedge core_clk);
		ang_ld <= 1'b0;
		rdr(bfd_pkg::ADDR_STEP_ANGLE);
		chk("angle", 32'h5, rd);
		u_host.pulse(20);
		chk("home", 32'(home), 32'(ang));
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		t_por();
		t_cfg();
		t_blank();
		t_retry();
		t_ol();
		t_angle(12'h800, bfd_pkg::HOME_OTHER);
		t_angle(12'hc00, bfd_pkg::HOME_SINGLE);
		print_verdict();
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		print_verdict();
	end
endmodule
